// >>> ipsq_top.sv
`timescale 1ns/1ps
module ipsq_top #(
  parameter logic [15:0] PERIOD_3W  = 16'(ipsq_pkg::PERIOD_3W_CYC),
  parameter logic [15:0] UV_TIMEOUT = 16'(ipsq_pkg::UV_TIMEOUT_CYC),
  parameter logic [15:0] BURST_2W   = 16'(ipsq_pkg::BURST_2W_CYC),
  parameter logic [15:0] ONE_SHOT   = 16'(ipsq_pkg::ONE_SHOT_CYC),
  parameter int unsigned FILT       = ipsq_pkg::FILT_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Enable from host
  input  wire logic        enable_in,
  // Primary rail comparators
  input  wire logic        primary_uv_ok,
  input  wire logic        primary_upper_level,
  input  wire logic        primary_charge_ok,
  // Secondary rail comparators
  input  wire logic        secondary_high_ok,
  input  wire logic        secondary_mid_ok,
  // Thermal sensor
  input  wire logic        over_temp,
  input  wire logic        temp_recovered,
  // Straps
  input  wire logic [2:0]  transfer_level_code,
  input  wire logic        one_shot_strap,
  // Outputs
  output logic             gate_drive_out,
  output logic             transfer_burst,
  output logic             gate_low_cmd,
  output logic             two_wire_mode,
  output logic [2:0]       transfer_level,
  output logic             thermal_shutdown,
  output logic             primary_uv
);

  typedef struct packed {
    ipsq_pkg::ipsq_state_t state;
    logic                  two_wire;
    logic                  one_shot;
    logic [2:0]            level;
    logic                  en_d;
    logic                  armed;
    logic                  burst;
    logic [15:0]           burst_cnt;
    logic [15:0]           period_cnt;
    logic [15:0]           uv_cnt;
    logic [15:0]           pulse_cnt;
    logic                  gate;
    logic                  low_cmd;
    logic                  hot_flag;
    logic                  uv_flag;
    logic [2:0]            code_s1;
    logic [2:0]            code_s2;
    logic                  strap_s1;
    logic                  strap_s2;
  } ipsq_core_t;

  localparam ipsq_core_t RST_VAL = '{
    state:      ipsq_pkg::IPSQ_ST_PWRUP,
    two_wire:   1'b0,
    one_shot:   1'b0,
    level:      ipsq_pkg::LEVEL_DEFAULT,
    en_d:       1'b0,
    armed:      1'b0,
    burst:      1'b0,
    burst_cnt:  16'h0000,
    period_cnt: 16'h0000,
    uv_cnt:     16'h0000,
    pulse_cnt:  16'h0000,
    gate:       1'b0,
    low_cmd:    1'b0,
    hot_flag:   1'b0,
    uv_flag:    1'b0,
    code_s1:    3'h0,
    code_s2:    3'h0,
    strap_s1:   1'b0,
    strap_s2:   1'b0
  };

  ipsq_core_t  q_ff;
  ipsq_core_t  nxt_q;
  ipsq_flag_if flags ();

  ////////////////////////////////////////////////////////////////////////////////
  // Three-wire on-time: duty of 2*(level+1)/15 of the period
  function automatic logic [15:0] on_time(input logic [2:0] lvl, input logic [15:0] per);
    logic [31:0] prod;
    prod = 32'(per) * 32'(ipsq_pkg::DUTY_STEP) * (32'(lvl) + 32'h1);
    return 16'(prod / 32'(ipsq_pkg::DUTY_DEN));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  ipsq_flag_filter #(
    .FILT (FILT)
  ) u_filter (
    .sys_clk (sys_clk),
    .srst    (srst),
    .raw     ({temp_recovered, over_temp, secondary_mid_ok, secondary_high_ok,
                primary_charge_ok, primary_upper_level, primary_uv_ok, enable_in}),
    .flags   (flags.filt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic rails_ok;
  logic en_rise;
  logic xfer_ok;
  logic want;

  always_comb begin
    nxt_q         = q_ff;
    nxt_q.low_cmd = 1'b0;
    nxt_q.en_d    = flags.en;
    // Strap pins pass two flip-flops before the power-up latch reads them
    nxt_q.code_s1  = transfer_level_code;
    nxt_q.code_s2  = q_ff.code_s1;
    nxt_q.strap_s1 = one_shot_strap;
    nxt_q.strap_s2 = q_ff.strap_s1;
    rails_ok      = flags.hi_ok & flags.mid_ok;
    en_rise       = flags.en & ~q_ff.en_d;
    want          = 1'b0;

    case (q_ff.state)
      ipsq_pkg::IPSQ_ST_PWRUP: begin
        if (flags.en && !flags.prim_ok) begin
          nxt_q.two_wire = 1'b1;
        end
        if (flags.prim_ok) begin
          nxt_q.state    = ipsq_pkg::IPSQ_ST_RUN;
          nxt_q.level    = (q_ff.code_s2 > ipsq_pkg::LEVEL_MAX) ?
                           ipsq_pkg::LEVEL_DEFAULT : q_ff.code_s2;
          nxt_q.one_shot = q_ff.strap_s2 & ~(q_ff.two_wire | flags.en);
          nxt_q.armed    = ~flags.en;
        end
      end
      ipsq_pkg::IPSQ_ST_RUN: begin
        if (!flags.prim_ok) begin
          nxt_q.state   = ipsq_pkg::IPSQ_ST_UV;
          nxt_q.uv_cnt  = '0;
          nxt_q.low_cmd = flags.prim_charge;
        end else if (flags.hot) begin
          nxt_q.state   = ipsq_pkg::IPSQ_ST_HOT;
        end
      end
      ipsq_pkg::IPSQ_ST_UV: begin
        if (q_ff.uv_cnt < UV_TIMEOUT) begin
          nxt_q.uv_cnt = q_ff.uv_cnt + 16'h0001;
        end
        if (flags.prim_ok) begin
          nxt_q.state = ipsq_pkg::IPSQ_ST_RUN;
        end
      end
      ipsq_pkg::IPSQ_ST_HOT: begin
        if (!flags.prim_ok) begin
          nxt_q.state  = ipsq_pkg::IPSQ_ST_UV;
          nxt_q.uv_cnt = '0;
        end else if (flags.cool && !flags.hot) begin
          nxt_q.state  = ipsq_pkg::IPSQ_ST_RUN;
        end
      end
      default: begin
        nxt_q.state = ipsq_pkg::IPSQ_ST_PWRUP;
      end
    endcase

    // Power transfer
    xfer_ok = (q_ff.state == ipsq_pkg::IPSQ_ST_RUN) && flags.prim_ok && !flags.hot &&
              (!q_ff.two_wire || flags.en);
    if (!xfer_ok) begin
      nxt_q.burst      = 1'b0;
      nxt_q.burst_cnt  = '0;
      nxt_q.period_cnt = '0;
    end else if (q_ff.two_wire) begin
      if (q_ff.burst) begin
        nxt_q.burst_cnt = q_ff.burst_cnt + 16'h0001;
        if (q_ff.burst_cnt >= BURST_2W - 16'h0001) begin
          nxt_q.burst     = 1'b0;
          nxt_q.burst_cnt = '0;
        end
      end else if (flags.prim_upper) begin
        nxt_q.burst = 1'b1;
      end
    end else begin
      nxt_q.period_cnt = (q_ff.period_cnt >= PERIOD_3W - 16'h0001) ?
                         16'h0000 : q_ff.period_cnt + 16'h0001;
      nxt_q.burst      = (q_ff.period_cnt < on_time(q_ff.level, PERIOD_3W));
    end

    // One-shot pulse timing
    if (!flags.en) begin
      nxt_q.armed = 1'b1;
    end
    if (q_ff.pulse_cnt != 16'h0000) begin
      nxt_q.pulse_cnt = q_ff.pulse_cnt - 16'h0001;
    end
    if (q_ff.one_shot && en_rise && q_ff.armed && rails_ok &&
        q_ff.state == ipsq_pkg::IPSQ_ST_RUN) begin
      nxt_q.pulse_cnt = ONE_SHOT;
      nxt_q.armed     = 1'b0;
    end

    // Gate drive
    if (q_ff.one_shot) begin
      want = (nxt_q.pulse_cnt != 16'h0000);
    end else begin
      want = flags.en;
    end
    case (q_ff.state)
      ipsq_pkg::IPSQ_ST_RUN: begin
        if (!flags.prim_ok) begin
          // Without charge the low command cannot be sent: hold until timeout
          nxt_q.gate = q_ff.gate & rails_ok & ~flags.prim_charge;
        end else begin
          nxt_q.gate = want & rails_ok & ~flags.hot;
        end
      end
      ipsq_pkg::IPSQ_ST_UV: begin
        if (flags.prim_charge || q_ff.uv_cnt >= UV_TIMEOUT) begin
          nxt_q.gate = 1'b0;
        end else begin
          nxt_q.gate = q_ff.gate & rails_ok;
        end
      end
      default: begin
        nxt_q.gate = 1'b0;
      end
    endcase

    nxt_q.hot_flag = (nxt_q.state == ipsq_pkg::IPSQ_ST_HOT);
    nxt_q.uv_flag  = (nxt_q.state == ipsq_pkg::IPSQ_ST_UV);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign gate_drive_out   = q_ff.gate;
  assign transfer_burst   = q_ff.burst;
  assign gate_low_cmd     = q_ff.low_cmd;
  assign two_wire_mode    = q_ff.two_wire;
  assign transfer_level   = q_ff.level;
  assign thermal_shutdown = q_ff.hot_flag;
  assign primary_uv       = q_ff.uv_flag;

endmodule

// >>> ipsq_pkg.sv
package ipsq_pkg;

  localparam int unsigned SYS_CLK_MHZ    = 200;
  localparam int unsigned NS_PER_US      = 1000;

  localparam int unsigned BURST_2W_NS    = 3300;
  localparam int unsigned BURST_2W_CYC   =
    (BURST_2W_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

  localparam int unsigned PERIOD_3W_NS   = 25000;
  localparam int unsigned PERIOD_3W_CYC  = (PERIOD_3W_NS * SYS_CLK_MHZ) / NS_PER_US;

  localparam int unsigned UV_TIMEOUT_NS  = 50000;
  localparam int unsigned UV_TIMEOUT_CYC = (UV_TIMEOUT_NS * SYS_CLK_MHZ) / NS_PER_US;

  localparam int unsigned ONE_SHOT_NS    = 2000;
  localparam int unsigned ONE_SHOT_CYC   = (ONE_SHOT_NS * SYS_CLK_MHZ) / NS_PER_US;

  localparam int unsigned FILT_CYC       = 8;

  localparam int unsigned CNT_W          = 16;
  localparam int unsigned LEVEL_W        = 3;
  localparam logic [2:0]  LEVEL_MAX      = 3'h6;
  localparam logic [2:0]  LEVEL_DEFAULT  = 3'h0;
  localparam int unsigned DUTY_STEP      = 2;
  localparam int unsigned DUTY_DEN       = 15;
  localparam int unsigned NUM_FLAGS      = 8;

  typedef enum logic [4:0] {
    IPSQ_ST_PWRUP = 5'h01,
    IPSQ_ST_RUN   = 5'h02,
    IPSQ_ST_UV    = 5'h04,
    IPSQ_ST_HOT   = 5'h08,
    IPSQ_ST_IDLE  = 5'h10
  } ipsq_state_t;

endpackage

// >>> ipsq_flag_if.sv
`timescale 1ns/1ps
interface ipsq_flag_if;
  logic en;
  logic prim_ok;
  logic prim_upper;
  logic prim_charge;
  logic hi_ok;
  logic mid_ok;
  logic hot;
  logic cool;

  modport filt (output en, prim_ok, prim_upper, prim_charge, hi_ok, mid_ok, hot, cool);
  modport core (input  en, prim_ok, prim_upper, prim_charge, hi_ok, mid_ok, hot, cool);
endinterface

// >>> ipsq_flag_filter.sv
`timescale 1ns/1ps
module ipsq_flag_filter #(
  parameter int unsigned FILT = ipsq_pkg::FILT_CYC
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  // Raw flags
  input  wire logic [ipsq_pkg::NUM_FLAGS-1:0] raw,
  // Conditioned flags
  ipsq_flag_if.filt                          flags
);

  typedef struct packed {
    logic [ipsq_pkg::NUM_FLAGS-1:0] s1;
    logic [ipsq_pkg::NUM_FLAGS-1:0] s2;
    logic [ipsq_pkg::CNT_W-1:0]     hi_cnt;
    logic [ipsq_pkg::CNT_W-1:0]     mid_cnt;
    logic                           hi_ok;
    logic                           mid_ok;
  } ipsq_filt_t;

  ipsq_filt_t q_ff;
  ipsq_filt_t nxt_q;

  localparam logic [ipsq_pkg::CNT_W-1:0] FILT_MAX = ipsq_pkg::CNT_W'(FILT);

  ////////////////////////////////////////////////////////////////////////////////
  // Dip filter: low must persist more than FILT cycles, recovery is immediate
  always_comb begin
    nxt_q    = q_ff;
    nxt_q.s1 = raw;
    nxt_q.s2 = q_ff.s1;
    if (q_ff.s2[4]) begin
      nxt_q.hi_cnt = '0;
      nxt_q.hi_ok  = 1'b1;
    end else if (q_ff.hi_cnt >= FILT_MAX) begin
      nxt_q.hi_ok = 1'b0;
    end else begin
      nxt_q.hi_cnt = q_ff.hi_cnt + 1'b1;
    end
    if (q_ff.s2[5]) begin
      nxt_q.mid_cnt = '0;
      nxt_q.mid_ok  = 1'b1;
    end else if (q_ff.mid_cnt >= FILT_MAX) begin
      nxt_q.mid_ok = 1'b0;
    end else begin
      nxt_q.mid_cnt = q_ff.mid_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign flags.en          = q_ff.s2[0];
  assign flags.prim_ok     = q_ff.s2[1];
  assign flags.prim_upper  = q_ff.s2[2];
  assign flags.prim_charge = q_ff.s2[3];
  assign flags.hi_ok       = q_ff.hi_ok;
  assign flags.mid_ok      = q_ff.mid_ok;
  assign flags.hot         = q_ff.s2[6];
  assign flags.cool        = q_ff.s2[7];

endmodule

// >>> ipsq_host.sv
`timescale 1ns/1ps
module ipsq_host (
  // Clock
  input  wire logic sys_clk,
  // Bench requests
  input  wire logic two_wire_req,
  input  wire logic want_on,
  // Supply seen by host
  input  wire logic primary_ok,
  // Enable to device
  output logic      enable_out
);
  logic [3:0] ok_d;
  logic       en_q;
  initial begin
    ok_d = 4'h0;
    en_q = 1'b0;
    enable_out = 1'b0;
  end
  // Requests sampled on the rising edge, clear of the bench's falling-edge drive
  always @(posedge sys_clk) begin
    ok_d <= {ok_d[2:0], primary_ok};
    // Two-wire leads supply, three-wire waits; one clean step each way
    en_q <= want_on && (two_wire_req || ok_d[3]);
  end
  always @(negedge sys_clk) begin
    enable_out <= en_q;
  end
endmodule

// >>> ipsq_props.sv
`timescale 1ns/1ps
module ipsq_props #(
  parameter logic [15:0] UV_TIMEOUT = 16'h2710,
  parameter logic [15:0] BURST_2W   = 16'h0294
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // Inputs
  input wire logic       enable_in,
  input wire logic       secondary_high_ok,
  input wire logic       over_temp,
  input wire logic       temp_recovered,
  // Outputs
  input wire logic       gate_drive_out,
  input wire logic       transfer_burst,
  input wire logic       two_wire_mode,
  input wire logic [2:0] transfer_level,
  input wire logic       thermal_shutdown,
  input wire logic       primary_uv
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [15:0] blen_ff;
  logic [15:0] uvc_ff;
  always_ff @(posedge sys_clk) begin
    blen_ff <= (srst || !transfer_burst) ? 16'h0 : blen_ff + 16'h1;
    uvc_ff  <= (srst || !primary_uv || uvc_ff == 16'hFFFF) ? 16'h0 : uvc_ff + 16'h1;
  end
  AST_BURST_LEN: assert property ($fell(transfer_burst) && two_wire_mode && enable_in
    && $past(enable_in, 5) && !primary_uv && !thermal_shutdown |-> blen_ff == BURST_2W)
    else $error("two-wire burst length wrong");
  AST_UV_NO_XFER: assert property ($past(primary_uv) && primary_uv |-> !transfer_burst)
    else $error("transfer during primary uv");
  AST_UV_TIMEOUT: assert property (primary_uv && uvc_ff > UV_TIMEOUT + 16'h3
    |-> !gate_drive_out) else $error("gate high after uv timeout");
  AST_RAIL_LOW: assert property ((!secondary_high_ok)[*8] ##1 (!secondary_high_ok)[*6]
    |-> !gate_drive_out) else $error("gate high with rail low");
  AST_GATE_RISE: assert property ($rose(gate_drive_out) |-> secondary_high_ok
    && !thermal_shutdown && !primary_uv) else $error("gate rose without valid rails");
  AST_EN_FALL: assert property ((two_wire_mode && !enable_in)[*6]
    |-> !gate_drive_out && !transfer_burst) else $error("two-wire stays on after enable fall");
  AST_HOT: assert property ($past(thermal_shutdown) && thermal_shutdown
    |-> !gate_drive_out && !transfer_burst) else $error("activity in thermal shutdown");
  AST_HOT_EXIT: assert property ((temp_recovered && !over_temp)[*6]
    |-> !thermal_shutdown) else $error("no resume after cooling");
  AST_LATCH: assert property (transfer_burst |=> $stable(transfer_level)
    && $stable(two_wire_mode)) else $error("latched setting changed");
  AST_LEVEL: assert property (transfer_level <= 3'h6) else $error("level out of range");
  AST_RST: assert property ($past(srst) |-> !gate_drive_out && !transfer_burst)
    else $error("output high after reset");
  cover property ($fell(transfer_burst) && two_wire_mode);
  cover property (thermal_shutdown);
  cover property (primary_uv && uvc_ff > UV_TIMEOUT);
  cover property ($fell(gate_drive_out) && !two_wire_mode && enable_in);
endmodule
bind ipsq_top ipsq_props #(.UV_TIMEOUT(UV_TIMEOUT), .BURST_2W(BURST_2W)) u_props (
  .sys_clk(sys_clk), .srst(srst), .enable_in(enable_in),
  .secondary_high_ok(secondary_high_ok), .over_temp(over_temp),
  .temp_recovered(temp_recovered), .gate_drive_out(gate_drive_out),
  .transfer_burst(transfer_burst), .two_wire_mode(two_wire_mode),
  .transfer_level(transfer_level), .thermal_shutdown(thermal_shutdown),
  .primary_uv(primary_uv));

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk, srst, en, two_w, want, puv, pup, pch, shi, smid, ot, trec, seen, osh;
  logic [2:0] code, lvl;
  logic       gate, burst, glc, twm, ts, uv;
  int         error_cnt, n_checks, seed, i, k, hc;
  ipsq_top #(.PERIOD_3W(16'h003C), .UV_TIMEOUT(16'h0014), .BURST_2W(16'h0005),
    .ONE_SHOT(16'h0004), .FILT(8)) uut (
    .sys_clk(sys_clk), .srst(srst), .enable_in(en), .primary_uv_ok(puv),
    .primary_upper_level(pup), .primary_charge_ok(pch), .secondary_high_ok(shi),
    .secondary_mid_ok(smid), .over_temp(ot), .temp_recovered(trec),
    .transfer_level_code(code), .one_shot_strap(osh), .gate_drive_out(gate),
    .transfer_burst(burst), .gate_low_cmd(glc), .two_wire_mode(twm),
    .transfer_level(lvl), .thermal_shutdown(ts), .primary_uv(uv));
  ipsq_host host (.sys_clk(sys_clk), .two_wire_req(two_w), .want_on(want),
    .primary_ok(puv), .enable_out(en));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_lvl(input logic [2:0] c);
    return (c == 3'h7) ? 16'h0 : 16'(c);
  endfunction
  function automatic logic [15:0] exp_hi(input logic [15:0] l);
    return 16'(240 * (l + 1) / 15);
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_gate(input logic v);
    for (k = 0; k < 300 && gate !== v; k++) cyc(1);
  endtask
  task automatic rst(input logic tw, input logic [2:0] c);
    srst = 1; two_w = tw; want = 0; puv = 0; pup = 0; pch = 1;
    shi = 0; smid = 0; ot = 0; trec = 0; code = c;
    cyc(6);
    srst = 0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    error_cnt = 0; n_checks = 0; seed = 32'hd0351647;
    osh = 0;
    rst(1, 3'($random(seed)));
    want = 1; cyc(4); puv = 1; cyc(8);
    chk("mode", twm, 1);
    chk("level", lvl, exp_lvl(code));
    pup = 1; cyc(1); pup = 0;
    for (k = 0; k < 20 && burst !== 1; k++) cyc(1);
    for (hc = 0; hc < 99 && burst === 1; hc++) cyc(1);
    chk("burst", 16'(hc), 5);
    cyc(20); chk("gate rails low", gate, 0);
    shi = 1; smid = 1; wait_gate(1); chk("gate on", gate, 1);
    code = ~code; cyc(6); chk("level held", lvl, exp_lvl(~code));
    shi = 0; cyc(1 + ($random(seed) & 3)); shi = 1; cyc(10);
    chk("gate dip", gate, 1);
    smid = 0; cyc(20); chk("gate mid low", gate, 0);
    smid = 1; wait_gate(1);
    ot = 1; cyc(8); chk("hot", ts, 1); chk("hot gate", gate, 0);
    ot = 0; trec = 1; cyc(10); chk("cooled", ts, 0);
    wait_gate(1); chk("resume", gate, 1); trec = 0;
    puv = 0; seen = 0;
    for (k = 0; k < 20; k++) begin
      cyc(1); seen |= (glc === 1);
    end
    chk("low cmd", seen, 1); chk("uv", uv, 1); chk("uv gate", gate, 0);
    puv = 1; wait_gate(1); want = 0; cyc(10); chk("en fall", gate, 0);
    pup = 1; cyc(10); chk("no xfer", burst, 0); pup = 0;
    for (i = 0; i < 8; i++) begin
      rst(0, 3'(i));
      want = 1; shi = 1; smid = 1; cyc(10);
      chk("en held", en, 0);
      puv = 1; cyc(20);
      chk("mode3", twm, 0);
      chk("level3", lvl, exp_lvl(code));
      hc = 0;
      repeat (120) begin
        cyc(1); hc += (burst === 1);
      end
      chk("duty", 16'(hc), exp_hi(exp_lvl(code)));
      wait_gate(1); chk("follow hi", gate, 1);
      if (i < 7) begin
        want = 0; cyc(8); chk("follow lo", gate, 0);
      end
    end
    pch = 0; puv = 0; cyc(6); chk("uv stop", burst, 0);
    chk("uv hold", gate, 1);
    cyc(30); chk("timeout", gate, 0);
    osh = 1;
    rst(0, 3'($random(seed)));
    shi = 1; smid = 1; puv = 1; cyc(20);
    for (i = 0; i < 2; i++) begin
      want = 1; hc = 0;
      repeat (20) begin
        cyc(1); hc += (gate === 1);
      end
      chk("one shot", 16'(hc), 4);
      want = 0; cyc(8);
    end
    summarize();
  end
endmodule
